//--- madio_map.svh
// Register offsets, reset values and field constants of the address/IO port.
// Assumes a byte-addressed APB with 32-bit data, one word per register.
`ifndef MADIO_MAP_SVH
`define MADIO_MAP_SVH

`define MADIO_PORT_DIRECTION_ADDR 20'hEE000
`define MADIO_PORT_OUTPUT_DATA_ADDR 20'hFFFD0
`define MADIO_MODE_CTRL_ADDR 20'hFF000
`define MADIO_ADDR_WIDTH 20
`define MADIO_PORT_WIDTH 8
`define MADIO_DIR_RESET_EXPANDED 8'hFF
`define MADIO_DIR_RESET_SINGLE 8'h00
`define MADIO_DATA_RESET 8'h00
`define MADIO_DIR_READ_VALUE 8'hFF
`define MADIO_MODE_WIDTH 3
`define MADIO_MODE_ROM_EXP 3'h5
`define MADIO_MODE_SINGLE_LO 3'h6
`define MADIO_MODE_EXP_LO 3'h1
`define MADIO_MODE_EXP_HI 3'h4

`endif

//--- madio_pkg.sv
// Types shared by the address/IO port.
// Assumes madio_map.svh is compiled alongside.
package madio_pkg;

  typedef enum logic [1:0] {
    MADIO_CLASS_ADDR_BUS,
    MADIO_CLASS_ADDR_SEL,
    MADIO_CLASS_GPIO,
    MADIO_CLASS_NONE
  } madio_mode_class_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n;
  } madio_pins_t;

endpackage

//--- madio_port.sv
// Eight-pin port: low address byte output or per-pin general IO by mode.
// Assumes APB master on pclk, mode pins stable, standby levels from the
// system controller and bus controller address synchronous to pclk.
// Overview of operation
// - Modes 1 to 4 drive all eight pins as low address byte outputs.
// - Mode 5 drives address on pins with direction one, inputs elsewhere.
// - Mode 5 starts with every pin an input after reset.
// - Modes 6 and 7 make direction-one pins outputs, others inputs.
// - Modes 1 to 4 read direction as all ones and ignore writes.
// - Modes 5 to 7 accept direction writes, reads return all ones.
// - Reset and hardware standby load direction FF or 00 by mode.
// - Software standby keeps direction so outputs keep driving.
// - A general output pin drives its output data bit.
// - Data read gives pin level for inputs, stored bit for outputs.
// - Output data clears on reset and hardware standby, kept in software standby.
// - Direction register is eight bits, one per pin.
// - Dynamic memory row and column addresses appear on these pins.
//
// Added by the designer: the APB slave port.
`include "madio_map.svh"
`timescale 1ns/1ps
`default_nettype none

module madio_port
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] op_mode,
  input wire logic hw_standby,
  input wire logic sw_standby,
  input wire logic [7:0] bus_addr_low,
  input wire logic [7:0] low_address_byte_pins_in,
  output logic [7:0] low_address_byte_pins_out,
  output logic [7:0] low_address_byte_pins_oe_n
);

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  madio_pkg::madio_mode_class_t mode_class;
  logic [7:0] port_direction_reg;
  logic [7:0] port_output_data_reg;
  logic [7:0] eff_dir;
  logic [7:0] pin_level;
  logic mode_ready;
  madio_pkg::madio_pins_t next_pins;

  always_comb
  begin
    if (op_mode >= `MADIO_MODE_EXP_LO && op_mode <= `MADIO_MODE_EXP_HI)
    begin
      mode_class = madio_pkg::MADIO_CLASS_ADDR_BUS;
    end
    else if (op_mode == `MADIO_MODE_ROM_EXP)
    begin
      mode_class = madio_pkg::MADIO_CLASS_ADDR_SEL;
    end
    else if (op_mode >= `MADIO_MODE_SINGLE_LO)
    begin
      mode_class = madio_pkg::MADIO_CLASS_GPIO;
    end
    else
    begin
      mode_class = madio_pkg::MADIO_CLASS_NONE;
    end
  end

  // Direction used for data reads: forced ones in address bus modes
  assign eff_dir = (mode_class == madio_pkg::MADIO_CLASS_ADDR_BUS) ?
                   `MADIO_DIR_READ_VALUE : port_direction_reg;

  // Mode value is taken after reset release, not under the reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_ready <= 1'b0;
    end
    else
    begin
      mode_ready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // APB access
  // ----------------------------------------------------------------
  logic wr_en;
  logic rd_en;
  logic [19:0] addr_low;
  logic hit_dir;
  logic hit_data;
  logic hit_mode;

  assign addr_low = paddr[19:0];
  assign hit_dir = (addr_low == `MADIO_PORT_DIRECTION_ADDR);
  assign hit_data = (addr_low == `MADIO_PORT_OUTPUT_DATA_ADDR);
  assign hit_mode = (addr_low == `MADIO_MODE_CTRL_ADDR);
  assign wr_en = psel && penable && pwrite && pready;
  assign rd_en = psel && penable && !pwrite && pready;

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
    end
    else
    begin
      pready <= psel && !pready && !(penable && pready) && psel && penable;
    end
  end

  // ----------------------------------------------------------------
  // Direction register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port_direction_reg <= `MADIO_DIR_RESET_SINGLE;
    end
    else if (!mode_ready || hw_standby)
    begin
      // Reset value depends on mode
      if (mode_class == madio_pkg::MADIO_CLASS_ADDR_BUS)
      begin
        port_direction_reg <= `MADIO_DIR_RESET_EXPANDED;
      end
      else
      begin
        port_direction_reg <= `MADIO_DIR_RESET_SINGLE;
      end
    end
    else if (wr_en && hit_dir && !sw_standby)
    begin
      if (mode_class == madio_pkg::MADIO_CLASS_ADDR_BUS)
      begin
        port_direction_reg <= `MADIO_DIR_RESET_EXPANDED;
      end
      else
      begin
        port_direction_reg <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Output data register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port_output_data_reg <= `MADIO_DATA_RESET;
    end
    else if (hw_standby)
    begin
      port_output_data_reg <= `MADIO_DATA_RESET;
    end
    else if (wr_en && hit_data && !sw_standby)
    begin
      port_output_data_reg <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Read data and error
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (psel && penable && !pready)
    begin
      pslverr <= !(hit_dir || hit_data || hit_mode);
      if (pwrite)
      begin
        prdata <= 32'h0000_0000;
      end
      else if (hit_dir)
      begin
        prdata <= {24'h00_0000, `MADIO_DIR_READ_VALUE};
      end
      else if (hit_data)
      begin
        prdata <= {24'h00_0000, pin_level};
      end
      else if (hit_mode)
      begin
        prdata <= {29'h0000_0000, op_mode};
      end
      else
      begin
        prdata <= 32'h0000_0000;
      end
    end
    else
    begin
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive, one generate per pin
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `MADIO_PORT_WIDTH; gi = gi + 1)
    begin : g_pin
      always_comb
      begin
        pin_level[gi] = eff_dir[gi] ? port_output_data_reg[gi] :
                        low_address_byte_pins_in[gi];
        next_pins.out[gi] = 1'b0;
        next_pins.oe_n[gi] = 1'b1;
        case (mode_class)
          madio_pkg::MADIO_CLASS_ADDR_BUS:
          begin
            // Row and column phases both arrive on bus_addr_low
            next_pins.out[gi] = bus_addr_low[gi];
            next_pins.oe_n[gi] = 1'b0;
          end
          madio_pkg::MADIO_CLASS_ADDR_SEL:
          begin
            next_pins.out[gi] = bus_addr_low[gi];
            next_pins.oe_n[gi] = !port_direction_reg[gi];
          end
          madio_pkg::MADIO_CLASS_GPIO:
          begin
            next_pins.out[gi] = port_output_data_reg[gi];
            next_pins.oe_n[gi] = !port_direction_reg[gi];
          end
          default:
          begin
            next_pins.out[gi] = 1'b0;
            next_pins.oe_n[gi] = 1'b1;
          end
        endcase
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      low_address_byte_pins_out <= 8'h00;
      low_address_byte_pins_oe_n <= 8'hFF;
    end
    else
    begin
      low_address_byte_pins_out <= next_pins.out;
      low_address_byte_pins_oe_n <= next_pins.oe_n;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_addr_mode_drive: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_class == madio_pkg::MADIO_CLASS_ADDR_BUS) ##1
    ($past(mode_class) == madio_pkg::MADIO_CLASS_ADDR_BUS)
    |-> (low_address_byte_pins_oe_n == 8'h00 &&
         low_address_byte_pins_out == $past(bus_addr_low)))
    else $error("Address mode pins not driving bus address");
  a_mode5_select: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_class == madio_pkg::MADIO_CLASS_ADDR_SEL)
    |=> (low_address_byte_pins_oe_n == ~$past(port_direction_reg)))
    else $error("Mode 5 pin enables do not follow direction");
  a_mode5_reset_in: assert property (@(posedge pclk) disable iff (!presetn)
    (!mode_ready && op_mode == `MADIO_MODE_ROM_EXP) |=> (port_direction_reg == 8'h00))
    else $error("Mode 5 direction not cleared after reset");
  a_gpio_dir: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_class == madio_pkg::MADIO_CLASS_GPIO)
    |=> (low_address_byte_pins_oe_n == ~$past(port_direction_reg)))
    else $error("GPIO enables do not follow direction");
  a_dir_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_ready && !hw_standby && mode_class == madio_pkg::MADIO_CLASS_ADDR_BUS)
    |=> (port_direction_reg == 8'hFF))
    else $error("Direction changed in address bus mode");
  a_dir_read_ones: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready && !pwrite && hit_dir) |=> (prdata == 32'h0000_00FF))
    else $error("Direction read not all ones");
  a_hw_standby_data: assert property (@(posedge pclk) disable iff (!presetn)
    hw_standby |=> (port_output_data_reg == 8'h00))
    else $error("Data not cleared in hardware standby");
  a_sw_standby_keep: assert property (@(posedge pclk) disable iff (!presetn)
    (sw_standby && !hw_standby && mode_ready) |=> $stable(port_direction_reg))
    else $error("Direction changed in software standby");
  a_gpio_out: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_class == madio_pkg::MADIO_CLASS_GPIO)
    |=> (low_address_byte_pins_out == $past(port_output_data_reg)))
    else $error("GPIO output not from data register");

  c_addr_mode: cover property (@(posedge pclk) disable iff (!presetn)
    mode_class == madio_pkg::MADIO_CLASS_ADDR_BUS ##1 wr_en && hit_dir);
  c_mode5_out: cover property (@(posedge pclk) disable iff (!presetn)
    mode_class == madio_pkg::MADIO_CLASS_ADDR_SEL && port_direction_reg != 8'h00);
  c_gpio_read: cover property (@(posedge pclk) disable iff (!presetn)
    mode_class == madio_pkg::MADIO_CLASS_GPIO && rd_en && hit_data);
  c_sw_standby: cover property (@(posedge pclk) disable iff (!presetn)
    sw_standby && wr_en && hit_data);

endmodule

`default_nettype wire

//--- madio_pin_model.sv
// Board side of the port: what the pins carry back into the port.
// Assumes active-low enables; undriven pins show the board level.
`timescale 1ns/1ps
`default_nettype none

module madio_pin_model
(
  input wire logic [7:0] drive,
  input wire logic [7:0] oe_n,
  input wire logic [7:0] board,
  output logic [7:0] level
);
  // Driven pins read back the port's own value
  always_comb level = (drive & ~oe_n) | (board & oe_n);
endmodule

`default_nettype wire

//--- madio_port_tb_top.sv
// Self-checking bench of the address/IO port, every mode 1 to 7.
// Assumes APB answer within 20 cycles and pins one edge after a change.
`timescale 1ns/1ps
`default_nettype none

module madio_port_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] op_mode = 3'h1;
  logic hw_standby = 1'b0;
  logic sw_standby = 1'b0;
  logic [7:0] bus_addr_low = 8'h00;
  logic [7:0] board = 8'h00;
  logic [7:0] pin_in;
  logic [7:0] pin_out;
  logic [7:0] pin_oe_n;
  int errors = 0;
  int comparisons = 0;
  logic [31:0] rd;
  logic er;
  logic [7:0] ed;
  logic [7:0] ev;

  always #2.5 pclk = ~pclk;

  madio_port dut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .op_mode(op_mode),
    .hw_standby(hw_standby), .sw_standby(sw_standby),
    .bus_addr_low(bus_addr_low), .low_address_byte_pins_in(pin_in),
    .low_address_byte_pins_out(pin_out),
    .low_address_byte_pins_oe_n(pin_oe_n)
  );

  madio_pin_model board_side
  (
    .drive(pin_out), .oe_n(pin_oe_n), .board(board), .level(pin_in)
  );

  // --------------------------------
  // Checking, bus cycles, closing
  // --------------------------------
  task automatic wrap_up();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so the next call never re-drives psel in this step
    @(posedge pclk);
    if (n >= 20)
    begin
      errors++;
      wrap_up();
    end
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask

  // --------------------------------
  // Main sequence over modes 1 to 7
  // --------------------------------
  initial
  begin
    for (int m = 1; m <= 7; m++)
    begin
      op_mode <= m[2:0];
      bus_addr_low <= 8'h3C ^ m[7:0];
      board <= 8'hC3 ^ m[7:0];
      do_reset();
      ed = (m <= 4) ? 8'hFF : 8'h0F;
      ev = (m <= 5) ? (8'h3C ^ m[7:0]) : 8'hA5;
      chk("oe_n after reset", {24'h0, pin_oe_n}, (m <= 4) ? 32'h0 : 32'hFF);
      xfer(1'b0, 32'hEE000, 32'h0);
      chk("dir read", rd, 32'hFF);
      xfer(1'b1, 32'hFFFD0, 32'hA5);
      xfer(1'b1, 32'hEE000, 32'h0F);
      repeat (2) @(posedge pclk);
      chk("oe_n", {24'h0, pin_oe_n}, {24'h0, ~ed});
      chk("pins out", {24'h0, pin_out & ed}, {24'h0, ev & ed});
      xfer(1'b0, 32'hFFFD0, 32'h0);
      chk("data read", rd, {24'h0, (8'hA5 & ed) | (8'hC3 ^ m[7:0]) & ~ed});
      xfer(1'b0, 32'hFF100, 32'h0);
      chk("unmapped err", {31'h0, er}, 32'h1);
      sw_standby <= 1'b1;
      xfer(1'b1, 32'hEE000, 32'hF0);
      xfer(1'b1, 32'hFFFD0, 32'h00);
      repeat (2) @(posedge pclk);
      chk("oe_n in standby", {24'h0, pin_oe_n}, {24'h0, ~ed});
      sw_standby <= 1'b0;
      xfer(1'b0, 32'hFFFD0, 32'h0);
      chk("data kept", rd, {24'h0, (8'hA5 & ed) | (8'hC3 ^ m[7:0]) & ~ed});
      hw_standby <= 1'b1;
      repeat (2) @(posedge pclk);
      hw_standby <= 1'b0;
      repeat (3) @(posedge pclk);
      chk("oe_n after hw", {24'h0, pin_oe_n}, (m <= 4) ? 32'h0 : 32'hFF);
      xfer(1'b1, 32'hEE000, 32'hFF);
      xfer(1'b0, 32'hFFFD0, 32'h0);
      chk("data after hw", rd, 32'h0);
    end
    wrap_up();
  end
endmodule

`default_nettype wire
